// file: core/tksync_top.sv
// Option decode, global key suppression and alignment line sequencing
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////////////////////////
module tksync_top
    import tksync_pkg::*;
#(
    parameter int               CH        = NUM_CH,
    parameter logic [TMO_W-1:0] SHORT_CYC = TMO_W'(TMO_SHORT_CYC),
    parameter logic [TMO_W-1:0] LONG_CYC  = TMO_W'(TMO_LONG_CYC),
    parameter int               BURST_CYC = BURST_CYC_DEF
) (
    input  wire logic             clk_i,
    input  wire logic             sys_rst_i,
    input  wire logic             mode_strap_a_i,
    input  wire logic             mode_strap_b_i,
    input  wire logic             key_suppress_enable_i,
    input  wire logic             output_drive_select_i,
    input  wire logic             align_line_i,
    output logic                  align_line_o,
    output logic                  align_line_oe_o,
    input  wire logic [SIG_W-1:0] ch_signal_i,
    input  wire logic             ch_detect_i,
    output logic [CH-1:0]         burst_active_o,
    output logic [CH-1:0]         key_out_o,
    output logic [CH-1:0]         drift_hold_o,
    output logic [CH-1:0]         recal_o,
    output logic                  toggle_mode_o,
    output logic                  drive_open_o
);
    //////////////////////////////////////////////////////////////////////////////////////
    // Local functions

    function automatic tks_opt_s decode_opt(input logic a, input logic b,
                                            input logic sup, input logic oc);
        tks_opt_s o;
        o             = OPT_RESET;
        o.suppress_en = sup;
        o.drive_open  = oc;
        unique case ({a, b})
            {STRAP_LOW, STRAP_HIGH}:  o.tmo_sel = TKS_TMO_SHORT;
            {STRAP_HIGH, STRAP_LOW}:  o.tmo_sel = TKS_TMO_LONG;
            {STRAP_HIGH, STRAP_HIGH}: begin
                o.tmo_sel     = TKS_TMO_SHORT;
                o.toggle_mode = 1'b1;
            end
            default:                  o.tmo_sel = TKS_TMO_NONE;
        endcase
        return o;
    endfunction : decode_opt

    // True when any key other than idx has a set bit
    function automatic logic any_other(input logic [CH-1:0] v, input int idx);
        logic r;
        r = 1'b0;
        for (int k = 0; k < CH; k++) begin
            if (k != idx && v[k]) begin
                r = 1'b1;
            end
        end
        return r;
    endfunction : any_other

    //////////////////////////////////////////////////////////////////////////////////////
    // Declarations

    tks_seq_e             seq_r;
    tks_opt_s             opt_r;
    logic [BURST_W-1:0]   burst_cnt_r;
    logic [2:0]           ch_idx_r;
    logic                 line_sync;
    logic [SIG_W-1:0]     sig_r [CH];
    logic [CH-1:0]        det_r;
    logic [CH-1:0]        active_r;
    logic [CH-1:0]        pending;
    logic [CH-1:0]        stronger;
    logic [CH-1:0]        expire;
    logic [CH-1:0]        toggle_state_r;
    logic [CH-1:0]        det_prev_r;
    logic [CH-1:0]        pass;
    logic [CH-1:0]        live;
    logic [CH-1:0]        stuck_r;

    //////////////////////////////////////////////////////////////////////////////////////
    // Alignment line input

    tksync_sync2 u_sync (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .d_i       (align_line_i),
        .q_o       (line_sync)
    );

    //////////////////////////////////////////////////////////////////////////////////////
    // Acquisition sequencer

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            seq_r       <= TKS_WAIT_HIGH;
            burst_cnt_r <= '0;
            ch_idx_r    <= '0;
        end else begin
            unique case (seq_r)
                TKS_WAIT_HIGH: begin
                    if (line_sync) begin
                        seq_r       <= TKS_BURST;
                        ch_idx_r    <= '0;
                        burst_cnt_r <= '0;
                    end
                end
                TKS_BURST: begin
                    // One channel at a time, fixed order
                    if (burst_cnt_r == BURST_W'(BURST_CYC - 1)) begin
                        burst_cnt_r <= '0;
                        if (ch_idx_r == 3'(CH - 1)) begin
                            seq_r <= TKS_EVAL;
                        end else begin
                            ch_idx_r <= ch_idx_r + 3'd1;
                        end
                    end else begin
                        burst_cnt_r <= burst_cnt_r + BURST_W'(1);
                    end
                end
                TKS_EVAL: seq_r <= TKS_WAIT_HIGH;
                default:  seq_r <= TKS_WAIT_HIGH;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            burst_active_o <= '0;
        end else begin
            for (int k = 0; k < CH; k++) begin
                burst_active_o[k] <= (seq_r == TKS_BURST) && (ch_idx_r == 3'(k));
            end
        end
    end

    // Open drain: only ever drive low; oe high means pulling
    // Same lag as burst_active_o, so the pull never overlaps the first burst
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            align_line_o    <= 1'b0;
            align_line_oe_o <= 1'b0;
        end else begin
            align_line_o <= 1'b0;
            if (seq_r == TKS_BURST && ch_idx_r != 3'd0) begin
                align_line_oe_o <= 1'b1;
            end else begin
                align_line_oe_o <= 1'b0;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // Options, latched once per cycle

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            opt_r <= OPT_RESET;
        end else if (seq_r == TKS_EVAL) begin
            opt_r <= decode_opt(mode_strap_a_i, mode_strap_b_i,
                                key_suppress_enable_i, output_drive_select_i);
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            toggle_mode_o <= 1'b0;
            drive_open_o  <= 1'b0;
        end else begin
            toggle_mode_o <= opt_r.toggle_mode;
            drive_open_o  <= opt_r.drive_open;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // Per channel result capture at end of each burst

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            det_r <= '0;
            for (int k = 0; k < CH; k++) begin
                sig_r[k] <= '0;
            end
        end else if (seq_r == TKS_BURST && burst_cnt_r == BURST_W'(BURST_CYC - 1)) begin
            for (int k = 0; k < CH; k++) begin
                if (ch_idx_r == 3'(k)) begin
                    sig_r[k] <= ch_signal_i;
                    det_r[k] <= ch_detect_i;
                end
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // Global suppression, local to this chip only

    always_comb begin
        for (int k = 0; k < CH; k++) begin
            // A key stuck past its timeout stays out until it reads clear
            live[k]    = det_r[k] && !stuck_r[k];
            pending[k] = live[k] && !active_r[k];
        end
        for (int k = 0; k < CH; k++) begin
            stronger[k] = 1'b0;
            for (int j = 0; j < CH; j++) begin
                // Ties favour the lower index so one key always wins
                if (j != k && pending[j] &&
                    (sig_r[j] > sig_r[k] || (sig_r[j] == sig_r[k] && j < k))) begin
                    stronger[k] = 1'b1;
                end
            end
        end
        for (int k = 0; k < CH; k++) begin
            pass[k] = live[k] && (!opt_r.suppress_en ||
                      active_r[k] ||
                      (!any_other(active_r, k) && !stronger[k]));
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // Stuck key timers

    for (genvar g = 0; g < CH; g++) begin : g_tmr
        tksync_timer #(
            .SHORT_CYC (SHORT_CYC),
            .LONG_CYC  (LONG_CYC)
        ) u_tmr (
            .clk_i     (clk_i),
            .sys_rst_i (sys_rst_i),
            .run_i     (active_r[g] && det_r[g]),
            .sel_i     (opt_r.tmo_sel),
            .expire_o  (expire[g])
        );
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // Key state and outputs, updated in evaluation step and on timer expiry

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            active_r       <= '0;
            stuck_r        <= '0;
            det_prev_r     <= '0;
            toggle_state_r <= '0;
            key_out_o      <= '0;
            recal_o        <= '0;
            drift_hold_o   <= '0;
        end else begin
            recal_o <= '0;
            for (int k = 0; k < CH; k++) begin
                if (expire[k]) begin
                    // Recal drops the detection; key must re-detect to re-arm
                    active_r[k] <= 1'b0;
                    stuck_r[k]  <= 1'b1;
                    recal_o[k]  <= 1'b1;
                    if (!opt_r.toggle_mode) begin
                        key_out_o[k] <= 1'b0;
                    end else begin
                        key_out_o[k] <= toggle_state_r[k];
                    end
                end else if (seq_r == TKS_EVAL) begin
                    active_r[k]     <= pass[k];
                    det_prev_r[k]   <= pass[k];
                    stuck_r[k]      <= stuck_r[k] && det_r[k];
                    drift_hold_o[k] <= det_r[k];
                    if (opt_r.toggle_mode) begin
                        if (pass[k] && !det_prev_r[k]) begin
                            toggle_state_r[k] <= !toggle_state_r[k];
                            key_out_o[k]      <= !toggle_state_r[k];
                        end else begin
                            key_out_o[k] <= toggle_state_r[k];
                        end
                    end else begin
                        key_out_o[k] <= pass[k];
                    end
                end
            end
        end
    end

endmodule : tksync_top

// file: core/tksync_pkg.sv
// Shared constants and types for the touch key suppression and sync block
package tksync_pkg;

    localparam int          NUM_CH          = 5;
    localparam int          SIG_W           = 8;
    localparam int          CLK_HZ          = 100_000_000;
    localparam int          TMO_SHORT_S     = 10;
    localparam int          TMO_LONG_S      = 60;
    localparam longint      TMO_SHORT_CYC   = longint'(TMO_SHORT_S) * longint'(CLK_HZ);
    localparam longint      TMO_LONG_CYC    = longint'(TMO_LONG_S) * longint'(CLK_HZ);
    localparam int          TMO_W           = 33;
    localparam int          BURST_CYC_DEF   = 16;
    localparam int          BURST_W         = 16;
    localparam logic        STRAP_LOW       = 1'b0;
    localparam logic        STRAP_HIGH      = 1'b1;

    typedef enum logic [1:0] {
        TKS_TMO_NONE  = 2'b00,
        TKS_TMO_SHORT = 2'b01,
        TKS_TMO_LONG  = 2'b10
    } tks_tmo_e;

    typedef struct packed {
        logic     toggle_mode;
        tks_tmo_e tmo_sel;
        logic     suppress_en;
        logic     drive_open;
    } tks_opt_s;

    localparam tks_opt_s OPT_RESET = '{toggle_mode: 1'b0, tmo_sel: TKS_TMO_NONE,
                                       suppress_en: 1'b0, drive_open: 1'b0};

    typedef enum logic [1:0] {
        TKS_WAIT_HIGH = 2'b00,
        TKS_BURST     = 2'b01,
        TKS_EVAL      = 2'b10
    } tks_seq_e;

endpackage : tksync_pkg

// file: core/tksync_sync2.sv
// Two flop synchroniser for the alignment line
`timescale 1ns/100ps
module tksync_sync2
    import tksync_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    input  wire logic d_i,
    output logic      q_o
);
    logic meta_r;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            meta_r <= 1'b1;
            q_o    <= 1'b1;
        end else begin
            meta_r <= d_i;
            q_o    <= meta_r;
        end
    end
endmodule : tksync_sync2

// file: core/tksync_timer.sv
// Per channel stuck key timer
`timescale 1ns/100ps
module tksync_timer
    import tksync_pkg::*;
#(
    parameter logic [TMO_W-1:0] SHORT_CYC = TMO_W'(TMO_SHORT_CYC),
    parameter logic [TMO_W-1:0] LONG_CYC  = TMO_W'(TMO_LONG_CYC)
) (
    input  wire logic     clk_i,
    input  wire logic     sys_rst_i,
    input  wire logic     run_i,
    input  wire tks_tmo_e sel_i,
    output logic          expire_o
);
    logic [TMO_W-1:0] cnt_r;
    logic [TMO_W-1:0] limit;

    // Counted in clock cycles, so timeouts follow the oscillator
    always_comb begin
        unique case (sel_i)
            TKS_TMO_SHORT: limit = SHORT_CYC;
            TKS_TMO_LONG:  limit = LONG_CYC;
            default:       limit = '1;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !run_i || sel_i == TKS_TMO_NONE) begin
            cnt_r    <= '0;
            expire_o <= 1'b0;
        end else if (cnt_r >= limit - TMO_W'(1)) begin
            cnt_r    <= '0;
            expire_o <= 1'b1;
        end else begin
            cnt_r    <= cnt_r + TMO_W'(1);
            expire_o <= 1'b0;
        end
    end
endmodule : tksync_timer

// file: testbench/tksync_top_sva.sv
// Assertion checker for the suppression and alignment block
`timescale 1ns/100ps
module tksync_top_sva
    import tksync_pkg::*;
#(
    parameter int CH = NUM_CH
) (
    input wire logic             clk_i,
    input wire logic             sys_rst_i,
    input wire logic             mode_strap_a_i,
    input wire logic             mode_strap_b_i,
    input wire logic             key_suppress_enable_i,
    input wire logic             output_drive_select_i,
    input wire logic             align_line_i,
    input wire logic             align_line_o,
    input wire logic             align_line_oe_o,
    input wire logic [SIG_W-1:0] ch_signal_i,
    input wire logic             ch_detect_i,
    input wire logic [CH-1:0]    burst_active_o,
    input wire logic [CH-1:0]    key_out_o,
    input wire logic [CH-1:0]    drift_hold_o,
    input wire logic [CH-1:0]    recal_o,
    input wire logic             toggle_mode_o,
    input wire logic             drive_open_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    //////////////////////////////////////////////////////////////////////////////
    burst_onehot_a: assert property ($onehot0(burst_active_o))
        else $error("two bursts at once");
    burst_len_a: assert property ($rose(burst_active_o[0]) |->
        ##15 burst_active_o[0] ##1 burst_active_o[1]) else $error("burst length or order");
    line_low_only_a: assert property (!align_line_o)
        else $error("line driven high");
    first_release_a: assert property (burst_active_o[0] |-> !align_line_oe_o)
        else $error("line held in first burst");
    mid_hold_a: assert property ((|burst_active_o[CH-1:1]) |-> align_line_oe_o)
        else $error("line released early");
    last_release_a: assert property ($fell(burst_active_o[CH-1]) |-> !align_line_oe_o)
        else $error("line not released");
    start_wait_a: assert property (!align_line_i [*5] |=> !$rose(burst_active_o[0]))
        else $error("cycle started on low line");
    single_key_a: assert property ((key_suppress_enable_i &&
        |(key_out_o & ~$past(key_out_o))) |-> $onehot(key_out_o)) else $error("two keys");
    dc_clear_a: assert property (!toggle_mode_o && recal_o[0] |=> !key_out_o[0])
        else $error("output kept after timeout");
    toggle_keep_a: assert property (toggle_mode_o && recal_o[0] |=> $stable(key_out_o[0]))
        else $error("toggle output changed");
endmodule : tksync_top_sva

bind tksync_top tksync_top_sva #(.CH(CH)) sva_u (
    .clk_i                 (clk_i),
    .sys_rst_i             (sys_rst_i),
    .mode_strap_a_i        (mode_strap_a_i),
    .mode_strap_b_i        (mode_strap_b_i),
    .key_suppress_enable_i (key_suppress_enable_i),
    .output_drive_select_i (output_drive_select_i),
    .align_line_i          (align_line_i),
    .align_line_o          (align_line_o),
    .align_line_oe_o       (align_line_oe_o),
    .ch_signal_i           (ch_signal_i),
    .ch_detect_i           (ch_detect_i),
    .burst_active_o        (burst_active_o),
    .key_out_o             (key_out_o),
    .drift_hold_o          (drift_hold_o),
    .recal_o               (recal_o),
    .toggle_mode_o         (toggle_mode_o),
    .drive_open_o          (drive_open_o)
);

// file: testbench/tksync_peer.sv
// Peer chip model on the shared open drain alignment line
`timescale 1ns/100ps
module tksync_peer #(
    parameter int FAST_LOW = 20,
    parameter int SLOW_LOW = 400
) (
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    input  wire logic slow_i,
    input  wire logic line_i,
    output logic      pull_oe_o
);
    int   cnt_r;
    int   low_len;
    logic busy_r;

    assign low_len = slow_i ? SLOW_LOW : FAST_LOW;
    // Never drives high, only pulls low or lets go
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cnt_r     <= 0;
            busy_r    <= 1'b0;
            pull_oe_o <= 1'b0;
        end else if (!busy_r) begin
            busy_r <= line_i; // Restart only on a high line
            cnt_r  <= 0;
        end else begin
            cnt_r     <= cnt_r + 1;
            pull_oe_o <= (cnt_r >= 15) && (cnt_r < 15 + low_len);
            busy_r    <= (cnt_r < 15 + low_len);
        end
    end
endmodule : tksync_peer

// file: testbench/tksync_top_tb.sv
// Self-checking bench for the suppression and alignment block
`timescale 1ns/100ps
module tksync_top_tb;
    import tksync_pkg::*;
    localparam int SHORT = 200;
    localparam int LONG  = 1000;
    logic             clk_i, sys_rst_i, strap_a, strap_b, sup_en, drv_sel, slow;
    logic             line_w, dut_oe, line_o, peer_oe, detect, tog, dopen;
    logic [SIG_W-1:0] sig;
    logic [SIG_W-1:0] sig_tab [NUM_CH];
    logic [NUM_CH-1:0] burst, key_out, hold, recal, det_tab;
    int               fails, num_checks, n, cnt, gap;
    time              t0;
    int               lim_tab [4] = '{1500, SHORT, LONG, SHORT};
    //////////////////////////////////////////////////////////////////////////////
    // Pull-up wins only when every party lets go
    assign line_w = !(dut_oe || peer_oe);
    tksync_top #(.SHORT_CYC(33'(SHORT)), .LONG_CYC(33'(LONG))) dut_u (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .mode_strap_a_i(strap_a),
        .mode_strap_b_i(strap_b), .key_suppress_enable_i(sup_en),
        .output_drive_select_i(drv_sel), .align_line_i(line_w), .align_line_o(line_o),
        .align_line_oe_o(dut_oe), .ch_signal_i(sig), .ch_detect_i(detect),
        .burst_active_o(burst), .key_out_o(key_out), .drift_hold_o(hold),
        .recal_o(recal), .toggle_mode_o(tog), .drive_open_o(dopen));
    tksync_peer peer_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .slow_i(slow),
        .line_i(line_w), .pull_oe_o(peer_oe));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // Present the bursting channel's data
    always @(posedge clk_i) begin
        #1;
        sig = '0;
        detect = 1'b0;
        for (int i = 0; i < NUM_CH; i++) begin
            if (burst[i]) begin
                sig = sig_tab[i];
                detect = det_tab[i];
            end
        end
    end
    //////////////////////////////////////////////////////////////////////////////
    task automatic tick();
        @(posedge clk_i);
        #1;
    endtask : tick
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Wait for k new acquisition cycles to begin
    task automatic cycles(input int k);
        repeat (k) begin
            for (n = 0; n < 2000 && burst[0]; n++) tick();
            for (n = 0; n < 2000 && !burst[0]; n++) tick();
        end
    endtask : cycles
    task automatic final_report();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report
    //////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (40000) @(posedge clk_i);
        fails++;
        final_report();
    end
    initial begin
        {sys_rst_i, strap_a, strap_b, sup_en, drv_sel, slow} = 6'h20;
        {sig, detect, det_tab} = '0;
        sig_tab = '{8'h10, 8'h40, 8'h10, 8'h90, 8'h10};
        repeat (16) tick();
        sys_rst_i = 1'b0;
        check({key_out, dut_oe, tog}, '0);
        // Peer sets the pace: quick release, then a long hold
        cycles(2);
        t0 = $time;
        cycles(1);
        check(($time - t0) / 10 < 150, 1);
        slow = 1'b1;
        cycles(2);
        t0 = $time;
        cycles(1);
        check(($time - t0) / 10 > 400, 1);
        slow = 1'b0;
        // Global suppression across all channels
        sup_en = 1'b1;
        cycles(3);
        det_tab = 5'b01010;
        cycles(3);
        check(key_out, 5'b01000);
        check(hold[1], 1);
        sig_tab[1] = 8'hf0;
        cycles(3);
        check(key_out, 5'b01000);
        det_tab[3] = 1'b0;
        cycles(3);
        check(key_out, 5'b00010);
        det_tab = '0;
        sup_en = 1'b0;
        cycles(3);
        det_tab = 5'b00011;
        cycles(3);
        check(key_out, 5'b00011);
        det_tab = '0;
        cycles(3);
        // Strap modes: none, short, long, toggle
        for (int m = 0; m < 4; m++) begin
            {strap_a, strap_b} = 2'(m == 3 ? 3 : (m == 1 ? 1 : (m == 2 ? 2 : 0)));
            drv_sel = m[0];
            cycles(3);
            check(tog, m == 3);
            check(dopen, m[0]);
            det_tab[0] = 1'b1;
            for (n = 0; n < 500 && !key_out[0]; n++) tick();
            for (cnt = 0; cnt < 1500 && !recal[0]; cnt++) tick();
            check(cnt > lim_tab[m] - 100 && cnt < lim_tab[m] + 100, 1);
            tick();
            check(key_out[0], m == 3 || m == 0);
            det_tab[0] = 1'b0;
            cycles(3);
        end
        final_report();
    end
endmodule : tksync_top_tb
